/* rtl/tmc_master_cmd.sv */
// module: master command decoder with output gate, write prefetch and reset control
//
// Our own choices: the plain strobed port and the register offsets.
`default_nettype none
module tmc_master_cmd
  import tmc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic div_freq_in,
  input wire logic [4:0] tc_event_in,
  output logic [15:0] rdata_out,
  output logic divided_freq_output_out,
  output logic divided_freq_output_oe_out,
  output logic write_prefetch_en_out,
  output logic read_prefetch_en_out,
  output logic [4:0] cnt_disarm_out,
  output logic [4:0] terminal_count_out
);

  // decode an 8-bit command into its actions
  function automatic tmc_cmd_t decode_cmd(input logic [7:0] op);
    tmc_cmd_t c;
    c = '0;
    c.gate_off = (op == TMC_OP_GATE_OFF);
    c.gate_on = (op == TMC_OP_GATE_ON);
    c.wpf_dis = (op == TMC_OP_WPF_DIS);
    c.wpf_en = (op == TMC_OP_WPF_EN);
    c.mreset = (op == TMC_OP_MASTER_RST);
    if (op[7:5] == TMC_OP_LOAD_HI || op[7:5] == TMC_OP_LOAD_ARM_HI) begin
      c.load_sel = op[4:0];
    end
    return c;
  endfunction : decode_cmd

  logic [15:0] master_reg, master_next;
  logic wpf_dis_reg, wpf_dis_next;
  logic [15:0] cnt_mode_reg [TMC_NUM_CNT];
  logic [15:0] cnt_mode_next [TMC_NUM_CNT];
  logic [15:0] load_reg [TMC_NUM_CNT];
  logic [15:0] load_next [TMC_NUM_CNT];
  logic [15:0] hold_reg [TMC_NUM_CNT];
  logic [15:0] hold_next [TMC_NUM_CNT];
  logic [2:0] sel_reg, sel_next;
  logic [7:0] dptr_reg, dptr_next;
  logic [4:0] tc_reg, tc_next;
  logic [4:0] disarm_reg, disarm_next;
  logic [15:0] rdata_reg, rdata_next;
  logic divided_freq_output_reg, divided_freq_output_next;
  logic divided_freq_output_oe_reg, divided_freq_output_oe_next;
  tmc_cmd_t cmd;
  logic cmd_wr;
  logic soft_rst;

  assign cmd_wr = wr_in && (addr_in == TMC_ADDR_CMD);
  assign cmd = cmd_wr ? decode_cmd(wdata_in[7:0]) : '0; // unknown opcodes decode to nothing
  assign soft_rst = cmd.mreset;

  // master mode and write prefetch control
  always_comb begin
    master_next = master_reg;
    wpf_dis_next = wpf_dis_reg;
    if (soft_rst) begin
      master_next = TMC_MASTER_RST;
      wpf_dis_next = 1'b0; // master reset re-enables write prefetch
    end else if (wr_in && addr_in == TMC_ADDR_MASTER) begin
      master_next = wdata_in; // full word carries the gate bit too
    end else begin
      if (cmd.gate_off) begin
        master_next[TMC_GATE_BIT] = 1'b1;
      end
      if (cmd.gate_on) begin
        master_next[TMC_GATE_BIT] = 1'b0;
      end
      if (cmd.wpf_dis) begin
        wpf_dis_next = 1'b1;
      end
      if (cmd.wpf_en) begin
        wpf_dis_next = 1'b0;
      end
    end
  end

  // counter-side registers, pointer and terminal count
  always_comb begin
    sel_next = sel_reg;
    dptr_next = dptr_reg; // never reset
    tc_next = tc_reg;
    disarm_next = disarm_reg;
    for (int i = 0; i < TMC_NUM_CNT; i++) begin
      cnt_mode_next[i] = cnt_mode_reg[i];
      load_next[i] = load_reg[i];
      hold_next[i] = hold_reg[i];
    end
    if (wr_in && addr_in == TMC_ADDR_DPTR) begin
      dptr_next = wdata_in[7:0];
    end
    if (wr_in && addr_in == TMC_ADDR_CNT_SEL && wdata_in[2:0] < 3'(TMC_NUM_CNT)) begin
      sel_next = wdata_in[2:0];
    end
    if (wr_in && addr_in == TMC_ADDR_CNT_MODE) begin
      cnt_mode_next[sel_reg] = wdata_in;
    end
    if (wr_in && addr_in == TMC_ADDR_LOAD) begin
      load_next[sel_reg] = wdata_in;
    end
    if (wr_in && addr_in == TMC_ADDR_HOLD) begin
      hold_next[sel_reg] = wdata_in;
    end
    // a terminal count event wins over a same-cycle load
    tc_next = (tc_reg & ~cmd.load_sel) | tc_event_in;
    if (cmd.load_sel != 5'h00 && cmd_wr && wdata_in[7:5] == TMC_OP_LOAD_ARM_HI) begin
      disarm_next = disarm_reg & ~cmd.load_sel;
    end
    if (soft_rst) begin
      disarm_next = '1; // all counters disarmed
      tc_next = tc_event_in;
      for (int i = 0; i < TMC_NUM_CNT; i++) begin
        cnt_mode_next[i] = TMC_CNT_MODE_RST;
        load_next[i] = TMC_LOADHOLD_RST;
        hold_next[i] = TMC_LOADHOLD_RST;
      end
    end
  end

  // frequency output pin and read data
  always_comb begin
    // gated: pin pulled low with enable on; a one-cycle glitch at gate change is tolerated
    if (master_reg[TMC_GATE_BIT]) begin
      divided_freq_output_next = 1'b0;
    end else begin
      divided_freq_output_next = div_freq_in;
    end
    divided_freq_output_oe_next = 1'b1;
    rdata_next = 16'h0000;
    if (rd_in) begin
      case (addr_in)
        TMC_ADDR_MASTER: rdata_next = master_reg;
        TMC_ADDR_STATUS: rdata_next = {9'h000, wpf_dis_reg, tc_reg, master_reg[TMC_GATE_BIT]};
        TMC_ADDR_DPTR: rdata_next = {8'h00, dptr_reg};
        TMC_ADDR_CNT_MODE: rdata_next = cnt_mode_reg[sel_reg];
        TMC_ADDR_LOAD: rdata_next = load_reg[sel_reg];
        TMC_ADDR_HOLD: rdata_next = hold_reg[sel_reg];
        TMC_ADDR_CNT_SEL: rdata_next = {13'h0000, sel_reg};
        TMC_ADDR_TC_SET: rdata_next = {11'h000, disarm_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  // registers; data pointer deliberately has no reset
  always_ff @(posedge clk_sys_in) begin
    dptr_reg <= dptr_next;
    if (rst_in) begin
      master_reg <= TMC_MASTER_RST;
      wpf_dis_reg <= 1'b0;
      sel_reg <= 3'h0;
      tc_reg <= 5'h00;
      disarm_reg <= 5'h1f;
      rdata_reg <= 16'h0000;
      divided_freq_output_reg <= 1'b0;
      divided_freq_output_oe_reg <= 1'b0;
      for (int i = 0; i < TMC_NUM_CNT; i++) begin
        cnt_mode_reg[i] <= TMC_CNT_MODE_RST;
        load_reg[i] <= TMC_LOADHOLD_RST;
        hold_reg[i] <= TMC_LOADHOLD_RST;
      end
    end else begin
      master_reg <= master_next;
      wpf_dis_reg <= wpf_dis_next;
      sel_reg <= sel_next;
      tc_reg <= tc_next;
      disarm_reg <= disarm_next;
      rdata_reg <= rdata_next;
      divided_freq_output_reg <= divided_freq_output_next;
      divided_freq_output_oe_reg <= divided_freq_output_oe_next;
      for (int i = 0; i < TMC_NUM_CNT; i++) begin
        cnt_mode_reg[i] <= cnt_mode_next[i];
        load_reg[i] <= load_next[i];
        hold_reg[i] <= hold_next[i];
      end
    end
  end

  assign rdata_out = rdata_reg;
  assign divided_freq_output_out = divided_freq_output_reg;
  assign divided_freq_output_oe_out = divided_freq_output_oe_reg;
  assign write_prefetch_en_out = ~wpf_dis_reg;
  assign read_prefetch_en_out = 1'b1; // read prefetch is never stopped
  assign cnt_disarm_out = disarm_reg;
  assign terminal_count_out = tc_reg;

  // master mode word: single-bit commands must leave every other bit alone
  chk_gate_off_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd.gate_off && !(wr_in && addr_in == TMC_ADDR_MASTER) |=> master_reg[TMC_GATE_BIT]
      && master_reg[11:0] == $past(master_reg[11:0]) && master_reg[15:13] == $past(master_reg[15:13]))
    else $error("gate off did not set only bit 12");
  chk_gate_on_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd.gate_on |=> !master_reg[TMC_GATE_BIT] && master_reg[15:13] == $past(master_reg[15:13])
      && master_reg[11:0] == $past(master_reg[11:0]))
    else $error("gate on did not clear only bit 12");
  chk_word_gate_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_in && addr_in == TMC_ADDR_MASTER |=> master_reg == $past(wdata_in))
    else $error("master word write lost");
  chk_word_keeps_wpf: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_in && addr_in == TMC_ADDR_MASTER |=> $stable(write_prefetch_en_out))
    else $error("master word write touched prefetch");

  // frequency pin: gated means driven low, never floated
  chk_gated_low_out: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    master_reg[TMC_GATE_BIT] |=> !divided_freq_output_out && divided_freq_output_oe_out)
    else $error("gated output not held low");
  chk_ungated_follow: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !master_reg[TMC_GATE_BIT] |=> divided_freq_output_out == $past(div_freq_in))
    else $error("output does not follow divided source");
  chk_pin_driven: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    1'b1 |=> divided_freq_output_oe_out)
    else $error("frequency pin not driven");

  // write prefetch control
  chk_wpf_hold_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !write_prefetch_en_out && !cmd.wpf_en && !soft_rst |=> !write_prefetch_en_out)
    else $error("write prefetch re-enabled without cause");
  chk_wpf_dis_en: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd.wpf_dis |=> !write_prefetch_en_out && read_prefetch_en_out ##1 1'b1)
    else $error("prefetch disable wrong");
  chk_wpf_dis_master: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd.wpf_dis |=> $stable(master_reg))
    else $error("prefetch disable touched master mode");
  chk_wpf_resume: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd.wpf_en |=> write_prefetch_en_out && $stable(master_reg))
    else $error("prefetch enable wrong");
  chk_mreset_wpf: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    soft_rst |=> write_prefetch_en_out)
    else $error("master reset left write prefetch off");

  // software reset must match the power-on values, except that it keeps the counter select
  chk_mreset_vals: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    soft_rst |=> master_reg == TMC_MASTER_RST && cnt_disarm_out == 5'h1f
      && cnt_mode_reg[0] == TMC_CNT_MODE_RST && load_reg[4] == TMC_LOADHOLD_RST)
    else $error("master reset incomplete");
  chk_mreset_counters: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    soft_rst |=> cnt_mode_reg[4] == TMC_CNT_MODE_RST && cnt_mode_reg[2] == TMC_CNT_MODE_RST
      && load_reg[0] == TMC_LOADHOLD_RST && hold_reg[0] == TMC_LOADHOLD_RST && hold_reg[4] == TMC_LOADHOLD_RST)
    else $error("master reset left a counter register");
  chk_mreset_tc_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    soft_rst |=> terminal_count_out == $past(tc_event_in))
    else $error("master reset kept terminal count");
  // pointer is unknown until the host sets it, so compare it exactly, unknowns included
  chk_dptr_kept: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    soft_rst |=> dptr_reg === $past(dptr_reg))
    else $error("data pointer changed by reset");

  // terminal count and arming
  chk_load_ends_tc: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd.load_sel[0] && !tc_event_in[0] |=> !terminal_count_out[0])
    else $error("load did not end terminal count");
  chk_tc_event_wins: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    tc_event_in[0] |=> terminal_count_out[0])
    else $error("terminal count event lost");
  chk_arm_clears: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_wr && wdata_in[7:5] == TMC_OP_LOAD_ARM_HI |=> (cnt_disarm_out & $past(wdata_in[4:0])) == 5'h00)
    else $error("load and arm left a counter disarmed");
  chk_load_keeps_arm: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_wr && wdata_in[7:5] == TMC_OP_LOAD_HI |=> $stable(cnt_disarm_out))
    else $error("plain load changed arming");

  // undefined opcodes: nothing may move
  chk_bad_op_ignored: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_wr && cmd == '0 |=> $stable(master_reg) && $stable(wpf_dis_reg) && $stable(disarm_reg))
    else $error("undefined opcode changed state");
  chk_bad_op_tc: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cmd_wr && cmd == '0 && tc_event_in == 5'h00 |=> $stable(terminal_count_out))
    else $error("undefined opcode changed terminal count");

  // read path: data stand one cycle after the strobe, zero otherwise
  chk_read_master: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    rd_in && addr_in == TMC_ADDR_MASTER |=> rdata_out == $past(master_reg))
    else $error("master read data wrong");

endmodule : tmc_master_cmd
`default_nettype wire

/* rtl/tmc_pkg.sv */
// package: constants, opcodes and carriers for the timer master command decoder
`default_nettype none
package tmc_pkg;
  localparam int unsigned TMC_NUM_CNT = 5;
  // register offsets
  localparam logic [3:0] TMC_ADDR_CMD = 4'h0;
  localparam logic [3:0] TMC_ADDR_MASTER = 4'h1;
  localparam logic [3:0] TMC_ADDR_STATUS = 4'h2;
  localparam logic [3:0] TMC_ADDR_DPTR = 4'h3;
  localparam logic [3:0] TMC_ADDR_CNT_MODE = 4'h4;
  localparam logic [3:0] TMC_ADDR_LOAD = 4'h5;
  localparam logic [3:0] TMC_ADDR_HOLD = 4'h6;
  localparam logic [3:0] TMC_ADDR_CNT_SEL = 4'h7;
  localparam logic [3:0] TMC_ADDR_TC_SET = 4'h8;
  // field positions
  localparam int unsigned TMC_GATE_BIT = 12;
  // reset values
  localparam logic [15:0] TMC_MASTER_RST = 16'h0000;
  localparam logic [15:0] TMC_LOADHOLD_RST = 16'h0000;
  localparam logic [15:0] TMC_CNT_MODE_RST = 16'h0800;
  // opcodes
  localparam logic [7:0] TMC_OP_GATE_OFF = 8'hee;
  localparam logic [7:0] TMC_OP_GATE_ON = 8'he6;
  localparam logic [7:0] TMC_OP_WPF_DIS = 8'hf9;
  localparam logic [7:0] TMC_OP_WPF_EN = 8'hf8;
  localparam logic [7:0] TMC_OP_MASTER_RST = 8'hff;
  localparam logic [2:0] TMC_OP_LOAD_HI = 3'h2;
  localparam logic [2:0] TMC_OP_LOAD_ARM_HI = 3'h3;
  // decoded command carrier
  typedef struct packed {
    logic gate_off;
    logic gate_on;
    logic wpf_dis;
    logic wpf_en;
    logic mreset;
    logic [4:0] load_sel;
  } tmc_cmd_t;
endpackage : tmc_pkg
`default_nettype wire

/* verification/tmc_host_model.sv */
// host processor model driving the register port of the command decoder
`default_nettype none
module tmc_host_model
  import tmc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic [15:0] rdata_in,
  output logic [3:0] addr_out,
  output logic [15:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    addr_out = 4'h0;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one-cycle write; data inverted after release so stale data never looks valid
  task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_sys_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask : bus_write
  // read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask : bus_read
  // start-up sequence: soft reset, load all counters, legal pointer code
  task automatic host_init();
    bus_write(TMC_ADDR_CMD, 16'h00ff);
    bus_write(TMC_ADDR_CMD, 16'h005f);
    bus_write(TMC_ADDR_DPTR, 16'h0001);
  endtask : host_init
endmodule : tmc_host_model
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the master command decoder
`default_nettype none
module testbench;
  import tmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic div_freq = 1'b0;
  logic [4:0] tc_event = 5'h00;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, rd_val;
  logic wr, rd, divided_freq_output, divided_freq_output_oe, wpf_en, rpf_en;
  logic [4:0] disarm, tc;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  tmc_master_cmd u_tmc_master_cmd (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .div_freq_in(div_freq), .tc_event_in(tc_event), .rdata_out(rdata),
    .divided_freq_output_out(divided_freq_output), .divided_freq_output_oe_out(divided_freq_output_oe), .write_prefetch_en_out(wpf_en),
    .read_prefetch_en_out(rpf_en), .cnt_disarm_out(disarm), .terminal_count_out(tc));
  tmc_host_model u_tmc_host_model (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  // 125 MHz clock and a hang guard
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
    u_tmc_host_model.bus_read(a, rd_val);
    check(rd_val, exp, what);
  endtask : rd_chk
  task automatic wr_cmd(input logic [7:0] op);
    u_tmc_host_model.bus_write(TMC_ADDR_CMD, {8'h00, op});
  endtask : wr_cmd
  // lets the registered outputs settle past n edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc
  task automatic test_reset();
    rd_chk(TMC_ADDR_MASTER, 16'h0000, "master rst");
    rd_chk(TMC_ADDR_HOLD, 16'h0000, "hold rst");
    rd_chk(4'hf, 16'h0000, "unmapped");
    check({11'h0, disarm}, 16'h001f, "disarm rst");
    check({14'h0, divided_freq_output_oe, wpf_en}, 16'h0003, "oe wpf rst");
  endtask : test_reset
  task automatic test_gate();
    u_tmc_host_model.bus_write(TMC_ADDR_MASTER, 16'h0a5a);
    wr_cmd(TMC_OP_GATE_OFF);
    rd_chk(TMC_ADDR_MASTER, 16'h1a5a, "gate off");
    @(posedge clk_sys_in) div_freq <= 1'b1;
    cyc(2);
    check({14'h0, divided_freq_output_oe, divided_freq_output}, 16'h0002, "gated low");
    wr_cmd(TMC_OP_GATE_ON);
    rd_chk(TMC_ADDR_MASTER, 16'h0a5a, "gate on");
    check({15'h0, divided_freq_output}, 16'h0001, "ungated high");
    @(posedge clk_sys_in) div_freq <= 1'b0;
    cyc(2);
    check({15'h0, divided_freq_output}, 16'h0000, "ungated low");
    @(posedge clk_sys_in) div_freq <= 1'b1;
    u_tmc_host_model.bus_write(TMC_ADDR_MASTER, 16'h1000);
    cyc(2);
    check({15'h0, divided_freq_output}, 16'h0000, "word gate off");
    rd_chk(TMC_ADDR_STATUS, 16'h0001, "status gate");
    u_tmc_host_model.bus_write(TMC_ADDR_MASTER, 16'h0000);
    cyc(2);
    check({15'h0, divided_freq_output}, 16'h0001, "word gate on");
  endtask : test_gate
  task automatic test_prefetch();
    wr_cmd(TMC_OP_WPF_DIS);
    cyc(1);
    check({14'h0, wpf_en, rpf_en}, 16'h0001, "wpf off");
    wr_cmd(8'hfa);
    cyc(1);
    check({15'h0, wpf_en}, 16'h0000, "stays off");
    rd_chk(TMC_ADDR_STATUS, 16'h0040, "status wpf");
    wr_cmd(TMC_OP_WPF_EN);
    cyc(1);
    check({15'h0, wpf_en}, 16'h0001, "wpf on");
    rd_chk(TMC_ADDR_MASTER, 16'h0000, "no side effect");
  endtask : test_prefetch
  task automatic test_mreset();
    u_tmc_host_model.bus_write(TMC_ADDR_MASTER, 16'h5a5a);
    u_tmc_host_model.bus_write(TMC_ADDR_CNT_SEL, 16'h0000);
    u_tmc_host_model.bus_write(TMC_ADDR_CNT_MODE, 16'h1234);
    u_tmc_host_model.bus_write(TMC_ADDR_LOAD, 16'h00aa);
    wr_cmd(TMC_OP_WPF_DIS);
    wr_cmd(8'h7f);
    @(posedge clk_sys_in) tc_event <= 5'h1f;
    @(posedge clk_sys_in) tc_event <= 5'h00;
    check({11'h0, disarm}, 16'h0000, "armed");
    rd_chk(TMC_ADDR_STATUS, 16'h007f, "status tc");
    wr_cmd(8'h5f);
    cyc(1);
    check({11'h0, tc}, 16'h0000, "load ends tc");
    @(posedge clk_sys_in) tc_event <= 5'h15;
    @(posedge clk_sys_in) tc_event <= 5'h00;
    wr_cmd(TMC_OP_MASTER_RST);
    cyc(1);
    check({6'h0, tc, disarm}, 16'h001f, "soft rst tc");
    check({15'h0, wpf_en}, 16'h0001, "soft rst wpf");
    rd_chk(TMC_ADDR_TC_SET, 16'h001f, "disarm read");
    rd_chk(TMC_ADDR_MASTER, 16'h0000, "master");
    rd_chk(TMC_ADDR_CNT_MODE, TMC_CNT_MODE_RST, "cnt mode");
    rd_chk(TMC_ADDR_LOAD, 16'h0000, "load");
  endtask : test_mreset
  // main sequence: reset held six cycles, then the scenarios
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    test_reset();
    u_tmc_host_model.host_init();
    test_gate();
    test_prefetch();
    test_mreset();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
